// File: rtl/usb_ep_pkg.sv
package usb_ep_pkg;

  localparam logic [1:0]  EP_COUNT    = 2'h3;
  localparam logic [31:0] ADDR_CTRL0  = 32'h0000_0000;
  localparam logic [31:0] ADDR_CTRL1  = 32'h0000_0004;
  localparam logic [31:0] ADDR_CTRL2  = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000C;
  localparam logic [31:0] ADDR_PRIME  = 32'h0000_0010;
  localparam int          F_STALL     = 0;
  localparam int          F_TYPE      = 2;
  localparam int          F_INHIB     = 5;
  localparam int          F_TRST      = 6;
  localparam int          F_EN        = 7;
  localparam int          TX_HALF     = 16;
  localparam logic [1:0]  TYPE_CTRL   = 2'h0;
  localparam logic [1:0]  TYPE_ISO    = 2'h1;
  localparam logic [1:0]  TYPE_BULK   = 2'h2;
  localparam logic [1:0]  TYPE_INTR   = 2'h3;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {tok_setup, tok_in, tok_out, tok_ping} tok_e;
  typedef enum logic [2:0] {hs_none, hs_ack, hs_nak, hs_nyet, hs_stall,
                            hs_data} hs_e;
  typedef enum logic [1:0] {f_idle, f_desc, f_data} fetch_st_e;

  typedef struct packed {
    logic       en;
    logic       inhib;
    logic [1:0] typ;
    logic       stall;
  } epcfg_s;

  localparam epcfg_s CFG_EP0 = '{en: 1'b1, inhib: 1'b0, typ: TYPE_CTRL,
                                 stall: 1'b0};

  typedef struct packed {
    logic       valid;
    tok_e       pid;
    logic [1:0] ep;
    logic       data1;    // data packet pid of OUT/SETUP was DATA1
  } tok_s;

  typedef struct packed {
    logic       valid;
    hs_e        code;
    logic       rx_accept; // data packet kept (not a toggle repeat)
  } hs_s;

  typedef struct packed {
    logic       req;
    logic [2:0] idx;       // {endpoint, direction}, direction 1 = IN
    logic       data;      // 0 descriptor word, 1 leading data word
  } fetch_s;

endpackage : usb_ep_pkg

// File: rtl/usb_ep_manager.sv
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module usb_ep_manager
  import usb_ep_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [31:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire tok_s        i_tok,
  input  wire logic        i_bus_reset,
  output hs_s              o_hs,
  output logic [31:0]      o_tx_word,
  output fetch_s           o_fetch,
  input  wire logic        i_fetch_ack,
  input  wire logic [31:0] i_fetch_word
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    epcfg_s [5:0]      cfg;
    logic [5:0]        tog;
    logic [5:0]        primed;
    logic [5:0]        pend;
    logic [2:0]        refill;
    logic [2:0]        chan_ok;
    logic [2:0][31:0]  chan;
    logic [5:0][31:0]  desc;
    fetch_st_e         fst;
    logic              frefill;
    fetch_s            fetch;
    hs_s               hs;
    logic [31:0]       txw;
    logic              awr;
    logic              wr;
    logic              arr;
    logic              bv;
    logic              rv;
    logic              aw_got;
    logic              w_got;
    logic [31:0]       awa;
    logic [31:0]       wd;
    logic [3:0]        ws;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [2:0] idx_of(logic [1:0] ep, logic dir);
    idx_of = {ep, dir};
  endfunction : idx_of

  function automatic logic [15:0] half_of(epcfg_s c);
    half_of = '0;
    half_of[F_STALL]       = c.stall;
    half_of[F_TYPE +: 2]   = c.typ;
    half_of[F_INHIB]       = c.inhib;
    half_of[F_EN]          = c.en;
  endfunction : half_of

  function automatic epcfg_s cfg_of(logic [15:0] h);
    cfg_of.stall = h[F_STALL];
    cfg_of.typ   = h[F_TYPE +: 2];
    cfg_of.inhib = h[F_INHIB];
    cfg_of.en    = h[F_EN];
  endfunction : cfg_of

  // lowest set bit; the fetch engine serves requests in index order
  function automatic logic [2:0] first_set(logic [5:0] v);
    first_set = '0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction : first_set

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic [2:0]  rx;
    logic [2:0]  tx;
    logic [2:0]  di;
    logic [1:0]  ep;
    logic [15:0] h;
    epcfg_s      c;
    logic        ok;
    rx     = '0;
    tx     = '0;
    di     = '0;
    ep     = '0;
    h      = '0;
    c      = '0;
    ok     = 1'b0;
    s_next = s_reg;
    s_next.hs = '0;

    // token answers; numbers above the last endpoint are not ours
    ep = i_tok.ep;
    rx = idx_of(ep, 1'b0);
    tx = idx_of(ep, 1'b1);
    di = (i_tok.pid == tok_in) ? tx : rx;
    c  = s_reg.cfg[di];
    if (i_tok.valid && ep < EP_COUNT && c.en) begin
      s_next.hs.valid = 1'b1;
      if (i_tok.pid == tok_setup) begin
        if (s_reg.cfg[rx].typ == TYPE_CTRL) begin
          s_next.hs.code          = hs_ack;
          s_next.hs.rx_accept     = 1'b1;
          s_next.cfg[rx].stall    = 1'b0;
          s_next.cfg[tx].stall    = 1'b0;
          s_next.tog[rx]          = 1'b1;
          s_next.tog[tx]          = 1'b1;
          // a new setup makes any primed data stage stale
          s_next.primed[rx]       = 1'b0;
          s_next.primed[tx]       = 1'b0;
        end else begin
          s_next.hs.code = hs_stall;
        end
      end else if (c.stall) begin
        s_next.hs.code = hs_stall;
      end else if (!s_reg.primed[di] ||
                   (i_tok.pid == tok_in && !s_reg.chan_ok[ep])) begin
        // isochronous has no handshake phase
        s_next.hs.code = (c.typ == TYPE_ISO) ? hs_none : hs_nak;
      end else begin
        unique case (i_tok.pid)
          tok_in: begin
            s_next.hs.code     = hs_data;
            s_next.txw         = s_reg.chan[ep];
            s_next.tog[tx]     = ~s_reg.tog[tx];
            s_next.chan_ok[ep] = 1'b0;
            s_next.refill[ep]  = 1'b1;
          end
          tok_out: begin
            ok = c.inhib || (i_tok.data1 == s_reg.tog[rx]);
            s_next.hs.rx_accept = ok;
            if (ok) begin
              s_next.tog[rx] = ~s_reg.tog[rx];
            end
            s_next.hs.code = (c.typ == TYPE_ISO) ? hs_none : hs_ack;
          end
          default: begin
            s_next.hs.code = hs_ack;
          end
        endcase
      end
    end

    // descriptor and leading-data fetch engine
    unique case (s_reg.fst)
      f_idle: begin
        if (|s_reg.pend) begin
          s_next.fetch = '{req: 1'b1, idx: first_set(s_reg.pend),
                           data: 1'b0};
          s_next.frefill = 1'b0;
          s_next.fst     = f_desc;
        end else if (|s_reg.refill) begin
          s_next.fetch = '{req: 1'b1,
                           idx: idx_of(2'(first_set({3'h0, s_reg.refill})),
                                       1'b1),
                           data: 1'b1};
          s_next.frefill = 1'b1;
          s_next.fst     = f_data;
        end
      end
      f_desc: begin
        if (i_fetch_ack) begin
          s_next.desc[s_reg.fetch.idx] = i_fetch_word;
          s_next.pend[s_reg.fetch.idx] = 1'b0;
          if (s_reg.fetch.idx[0]) begin
            s_next.fetch.data = 1'b1;
            s_next.fst        = f_data;
          end else begin
            // receive side: nothing to preload
            s_next.primed[s_reg.fetch.idx] = 1'b1;
            s_next.fetch.req  = 1'b0;
            s_next.fst        = f_idle;
          end
        end
      end
      default: begin
        if (i_fetch_ack) begin
          s_next.chan[s_reg.fetch.idx[2:1]]    = i_fetch_word;
          s_next.chan_ok[s_reg.fetch.idx[2:1]] = 1'b1;
          if (s_reg.frefill) begin
            s_next.refill[s_reg.fetch.idx[2:1]] = 1'b0;
          end else begin
            s_next.primed[s_reg.fetch.idx] = 1'b1;
          end
          s_next.fetch.req = 1'b0;
          s_next.fst       = f_idle;
        end
      end
    endcase

    // register bus: write address and data arrive in either order
    if (i_awvalid && s_reg.awr) begin
      s_next.aw_got = 1'b1;
      s_next.awa    = i_awaddr;
    end
    if (i_wvalid && s_reg.wr) begin
      s_next.w_got = 1'b1;
      s_next.wd    = i_wdata;
      s_next.ws    = i_wstrb;
    end
    if (s_reg.bv && i_bready) begin
      s_next.bv = 1'b0;
    end
    // software writes come after token and fetch clears, so a set wins; bus reset comes last and wins
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bv) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bv     = 1'b1;
      s_next.bresp  = RESP_OKAY;
      if (s_reg.awa == ADDR_CTRL0 || s_reg.awa == ADDR_CTRL1 ||
          s_reg.awa == ADDR_CTRL2) begin
        ep = s_reg.awa[3:2];
        for (int d = 0; d < 2; d++) begin
          // all fields of a half sit in its low byte
          if (s_reg.ws[2 * d]) begin
            h  = s_reg.wd[d * TX_HALF +: 16];
            di = idx_of(ep, 1'(d));
            c  = cfg_of(h);
            if (ep == 2'h0) begin
              c.typ = TYPE_CTRL;
              c.en  = 1'b1;
            end
            s_next.cfg[di] = c;
            if (h[F_TRST]) begin
              s_next.tog[di] = 1'b0;
            end
          end
        end
      end else if (s_reg.awa == ADDR_PRIME) begin
        for (int e = 0; e < 3; e++) begin
          for (int d = 0; d < 2; d++) begin
            di = idx_of(2'(e), 1'(d));
            if (s_reg.ws[2 * d] && s_reg.wd[d * TX_HALF + e] &&
                s_reg.cfg[di].en && !s_reg.primed[di]) begin
              s_next.pend[di] = 1'b1;
            end
          end
        end
      end else if (s_reg.awa != ADDR_STATUS) begin
        s_next.bresp = RESP_SLVERR;
      end
    end
    s_next.awr = !s_next.aw_got && !s_next.bv;
    s_next.wr  = !s_next.w_got && !s_next.bv;

    // register bus: reads
    if (s_reg.rv && i_rready) begin
      s_next.rv = 1'b0;
    end
    if (i_arvalid && s_reg.arr) begin
      s_next.rv    = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = '0;
      if (i_araddr == ADDR_CTRL0 || i_araddr == ADDR_CTRL1 ||
          i_araddr == ADDR_CTRL2) begin
        ep = i_araddr[3:2];
        s_next.rdata = {half_of(s_reg.cfg[idx_of(ep, 1'b1)]),
                        half_of(s_reg.cfg[idx_of(ep, 1'b0)])};
      end else if (i_araddr == ADDR_STATUS || i_araddr == ADDR_PRIME) begin
        for (int e = 0; e < 3; e++) begin
          for (int d = 0; d < 2; d++) begin
            di = idx_of(2'(e), 1'(d));
            s_next.rdata[d * TX_HALF + e] = (i_araddr == ADDR_STATUS) ?
                                            s_reg.primed[di] :
                                            s_reg.pend[di];
          end
        end
      end else begin
        s_next.rresp = RESP_SLVERR;
      end
    end
    s_next.arr = !s_next.rv;

    // bus reset: endpoint 0 survives, everything primed is dropped
    if (i_bus_reset) begin
      for (int i = 2; i < 6; i++) begin
        s_next.cfg[i].en = 1'b0;
      end
      s_next.primed  = '0;
      s_next.pend    = '0;
      s_next.refill  = '0;
      s_next.chan_ok = '0;
      s_next.fetch   = '0;
      s_next.fst     = f_idle;
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_reg        <= '0;
      s_reg.cfg[0] <= CFG_EP0;
      s_reg.cfg[1] <= CFG_EP0;
    end else begin
      s_reg <= s_next;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all straight from the state register
  // -----------------------------------------------------------------
  assign o_awready = s_reg.awr;
  assign o_wready  = s_reg.wr;
  assign o_bvalid  = s_reg.bv;
  assign o_bresp   = s_reg.bresp;
  assign o_arready = s_reg.arr;
  assign o_rvalid  = s_reg.rv;
  assign o_rdata   = s_reg.rdata;
  assign o_rresp   = s_reg.rresp;
  assign o_hs      = s_reg.hs;
  assign o_tx_word = s_reg.txw;
  assign o_fetch   = s_reg.fetch;

endmodule : usb_ep_manager

// File: verif/usb_ep_properties.sv
`timescale 1ns/10ps
module usb_ep_properties
  import usb_ep_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire tok_s        i_tok,
  input wire logic        i_bus_reset,
  input wire hs_s         o_hs,
  input wire logic [31:0] o_tx_word,
  input wire fetch_s      o_fetch,
  input wire logic        i_fetch_ack
);
  // ------------------------------------------------------------
  // token answers and fetch port
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // answers never appear on their own, one edge after the token
  property p_hs_cause; o_hs.valid |-> $past(i_tok.valid); endproperty
  property p_ep_range; i_tok.valid && i_tok.ep == 2'h3 |=> !o_hs.valid;
  endproperty
  property p_ep0_setup;
    i_tok.valid && i_tok.ep == 2'h0 && i_tok.pid == tok_setup
      |=> o_hs.valid && o_hs.code == hs_ack && o_hs.rx_accept;
  endproperty
  // fetch request is dropped at once, a late ack must not matter
  property p_bus_reset; i_bus_reset |=> !o_fetch.req; endproperty
  property p_req_hold;
    o_fetch.req && !i_fetch_ack && !i_bus_reset
      |=> o_fetch.req && $stable(o_fetch.idx) && $stable(o_fetch.data);
  endproperty
  property p_tx_lead;
    o_fetch.req && !o_fetch.data && o_fetch.idx[0] && i_fetch_ack
      && !i_bus_reset |=> o_fetch.req && o_fetch.data
      && o_fetch.idx == $past(o_fetch.idx);
  endproperty
  property p_rx_nodata; o_fetch.req && !o_fetch.idx[0] |-> !o_fetch.data;
  endproperty
  property p_tx_hold;
    !(o_hs.valid && o_hs.code == hs_data) |-> $stable(o_tx_word);
  endproperty

  a_hs_cause: assert property (p_hs_cause)
    else $error("answer without a token");
  a_ep_range: assert property (p_ep_range)
    else $error("answer to endpoint three");
  a_ep0_setup: assert property (p_ep0_setup)
    else $error("setup on endpoint zero not acked");
  a_bus_reset: assert property (p_bus_reset)
    else $error("fetch kept through bus reset");
  a_req_hold: assert property (p_req_hold)
    else $error("fetch request not held");
  a_tx_lead: assert property (p_tx_lead)
    else $error("no leading data fetch after descriptor");
  a_rx_nodata: assert property (p_rx_nodata)
    else $error("data fetch on receive direction");
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit word changed without transmit");

  c_tx_data: cover property (o_hs.valid && o_hs.code == hs_data);
  c_stall: cover property (o_hs.valid && o_hs.code == hs_stall);
  c_lead: cover property (o_fetch.req && o_fetch.data);
endmodule : usb_ep_properties

bind usb_ep_manager usb_ep_properties u_props (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_tok(i_tok),
  .i_bus_reset(i_bus_reset), .o_hs(o_hs), .o_tx_word(o_tx_word),
  .o_fetch(o_fetch), .i_fetch_ack(i_fetch_ack)
);

// File: verif/usb_host_model.sv
`timescale 1ns/10ps
module usb_host_model
  import usb_ep_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [3:0]  i_delay,
  input  wire fetch_s      i_fetch,
  output tok_s             o_tok,
  output logic             o_ack,
  output logic [31:0]      o_word
);
  // ------------------------------------------------------------
  // host tokens and memory answers
  // ------------------------------------------------------------
  logic [3:0] cnt;

  initial o_tok = '0;

  // one token per call; idle fields change so nothing stale is read
  task automatic send(input tok_e p, input logic [1:0] e, input logic d);
    @(posedge i_clk);
    o_tok <= '{valid: 1'b1, pid: p, ep: e, data1: d};
    @(posedge i_clk);
    o_tok <= '{valid: 1'b0, pid: tok_e'(~p), ep: ~e, data1: ~d};
  endtask : send

  // memory waits i_delay cycles, so both prompt and slow answers occur
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_ack  <= 1'b0;
      cnt    <= 4'h0;
      o_word <= 32'h0000_0000;
    end else if (o_ack || !i_fetch.req) begin
      o_ack  <= 1'b0;
      cnt    <= 4'h0;
      o_word <= ~o_word;
    end else if (cnt >= i_delay) begin
      o_ack  <= 1'b1;
      o_word <= {16'hc0de, 12'h000, i_fetch.data, i_fetch.idx};
    end else begin
      cnt    <= cnt + 4'h1;
      o_word <= ~o_word;
    end
  end
endmodule : usb_host_model

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench import usb_ep_pkg::*;;
  // ------------------------------------------------------------
  // signals, design and partner
  // ------------------------------------------------------------
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        bus_reset, awready, wready, bvalid, arready, rvalid, ack;
  logic [31:0] awaddr, wdata, araddr, rdata, tx_word, word;
  logic [3:0]  wstrb, delay;
  logic [1:0]  bresp, rresp;
  tok_s        tok;
  hs_s         hs;
  fetch_s      fetch;
  int          n_fail = 0, checked = 0, cyc = 0;

  usb_ep_manager dut (
    .i_clk(clk), .i_rstn(rstn), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .i_tok(tok), .i_bus_reset(bus_reset),
    .o_hs(hs), .o_tx_word(tx_word), .o_fetch(fetch), .i_fetch_ack(ack),
    .i_fetch_word(word)
  );
  usb_host_model host (
    .i_clk(clk), .i_rstn(rstn), .i_delay(delay), .i_fetch(fetch),
    .o_tok(tok), .o_ack(ack), .o_word(word)
  );

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // bus master: hold each channel until its ready, response awaited
  // no cycle limit of its own: a missing answer is left to the hang guard
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic wok(input logic [31:0] a, d, input logic [3:0] s);
    logic [1:0] r;
    wr(a, d, s, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask : wok

  task automatic rdchk(input logic [31:0] a, e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask : rdchk

  task automatic wait_st(input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd(ADDR_STATUS, d, r);
      n++;
    end while ((d & m) !== m && n < 50);
    chk(d & m, m);
  endtask : wait_st

  task automatic tk(input tok_e p, input logic [1:0] e, input logic d,
                    input logic v, input hs_e c);
    host.send(p, e, d);
    #1;
    chk(32'({hs.valid, hs.code}), 32'({v, c}));
  endtask : tk

  task automatic ta(input logic d, input logic acc);
    tk(tok_out, 2'h1, d, 1'b1, hs_ack);
    chk(32'(hs.rx_accept), 32'(acc));
  endtask : ta

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rdchk(ADDR_CTRL0, 32'h0080_0080);
    rdchk(ADDR_CTRL1, 32'h0000_0000);
    rdchk(ADDR_CTRL2, 32'h0000_0000);
    rd(32'h0000_0014, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(32'h0000_0014, 32'h0000_0000, 4'hf, r);
    chk(32'(r), 32'(RESP_SLVERR));
    tk(tok_out, 2'h1, 1'b0, 1'b0, hs_none);
    tk(tok_in, 2'h3, 1'b0, 1'b0, hs_none);
  endtask : t_reset

  // every type code, both halves alike; toggle reset reads back zero
  task automatic t_types();
    logic [31:0] c;
    for (int t = 0; t < 4; t++) begin
      c = 32'h00c0_00c0 | (32'(t) << 2) | (32'(t) << 18);
      wok(ADDR_CTRL1, c, 4'hf);
      rdchk(ADDR_CTRL1, c & 32'hffbf_ffbf);
      tk(tok_setup, 2'h1, 1'b0, 1'b1, t == 0 ? hs_ack : hs_stall);
      tk(tok_out, 2'h1, 1'b0, 1'b1, t == 1 ? hs_none : hs_nak);
    end
  endtask : t_types

  task automatic t_stall();
    wok(ADDR_CTRL1, 32'h00c8_00c8, 4'hf);
    wok(ADDR_CTRL1, 32'hffff_0089, 4'h1);
    rdchk(ADDR_CTRL1, 32'h0088_0089);
    tk(tok_out, 2'h1, 1'b0, 1'b1, hs_stall);
    tk(tok_ping, 2'h1, 1'b0, 1'b1, hs_stall);
    tk(tok_in, 2'h1, 1'b0, 1'b1, hs_nak);
    tk(tok_setup, 2'h1, 1'b0, 1'b1, hs_stall);
    rdchk(ADDR_CTRL1, 32'h0088_0089);
    wok(ADDR_CTRL1, 32'h0088_0088, 4'hf);
    tk(tok_out, 2'h1, 1'b0, 1'b1, hs_nak);
  endtask : t_stall

  task automatic t_ctrl_stall();
    wok(ADDR_CTRL0, 32'h0081_0081, 4'hf);
    tk(tok_in, 2'h0, 1'b0, 1'b1, hs_stall);
    tk(tok_setup, 2'h0, 1'b0, 1'b1, hs_ack);
    rdchk(ADDR_CTRL0, 32'h0080_0080);
    tk(tok_in, 2'h0, 1'b0, 1'b1, hs_nak);
  endtask : t_ctrl_stall

  // slow memory; toggle sequence with repeat, inhibit and reset
  task automatic t_rx_toggle();
    delay <= 4'h6;
    wok(ADDR_CTRL1, 32'h0000_00c8, 4'h1);
    wok(ADDR_PRIME, 32'h0000_0002, 4'hf);
    wait_st(32'h0000_0002);
    ta(1'b0, 1'b1);
    ta(1'b0, 1'b0);
    ta(1'b1, 1'b1);
    wok(ADDR_CTRL1, 32'h0000_00a8, 4'h1);
    ta(1'b1, 1'b1);
    wok(ADDR_CTRL1, 32'h0000_00c8, 4'h1);
    ta(1'b0, 1'b1);
  endtask : t_rx_toggle

  // prompt memory; leading word sent, then refilled for a second IN
  task automatic t_tx();
    delay <= 4'h0;
    wok(ADDR_CTRL2, 32'h00c8_0000, 4'h4);
    wok(ADDR_PRIME, 32'h0004_0000, 4'hf);
    wait_st(32'h0004_0002);
    tk(tok_in, 2'h2, 1'b0, 1'b1, hs_data);
    chk(tx_word, 32'hc0de_000d);
    tk(tok_out, 2'h2, 1'b0, 1'b0, hs_none);
    repeat (10) @(posedge clk);
    tk(tok_in, 2'h2, 1'b0, 1'b1, hs_data);
    chk(tx_word, 32'hc0de_000d);
  endtask : t_tx

  task automatic t_bus_reset();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    rdchk(ADDR_STATUS, 32'h0000_0000);
    rd(ADDR_CTRL1, d, r);
    chk(d & 32'h0080_0080, 32'h0000_0000);
    rdchk(ADDR_CTRL0, 32'h0080_0080);
    tk(tok_in, 2'h2, 1'b0, 1'b0, hs_none);
    tk(tok_setup, 2'h0, 1'b0, 1'b1, hs_ack);
  endtask : t_bus_reset

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // reset for three cycles, then every scenario in turn
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, bus_reset} = 6'h00;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    delay = 4'h2;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_types();
    t_stall();
    t_ctrl_stall();
    t_rx_toggle();
    t_tx();
    t_bus_reset();
    give_verdict();
  end
endmodule : testbench
